// >>> blink_gen.v
// blink_gen.v: free-running square wave with a programmable half period
// assumes one clock domain; output toggles every half_cycles clock edges
`timescale 1ns/1ps
`default_nettype none

module blink_gen #(
  parameter integer HALF_CYCLES = 10000000
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // square wave
  output reg wave
);

  reg [31:0] count;

  // ==========================================
  // half-period counter
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= 32'h0;
      wave <= 1'b0;
    end else if (count >= HALF_CYCLES - 1) begin
      count <= 32'h0;
      wave <= ~wave;
    end else begin
      count <= count + 32'h1;
    end
  end

endmodule

`default_nettype wire

// >>> led_map.vh
// led_map.vh: timing constants and code values for the front-panel status display
// assumes a 100 MHz system clock; included by the display module
`ifndef LED_MAP_VH
`define LED_MAP_VH

// ==========================================
// clock and blink timing
`define CLOCK_HZ 100000000
`define FAST_BLINK_MS 200
`define SLOW_BLINK_MS 1400
`define FAST_HALF_CYCLES ((`CLOCK_HZ / 1000) * `FAST_BLINK_MS / 2)
`define SLOW_HALF_CYCLES ((`CLOCK_HZ / 1000) * `SLOW_BLINK_MS / 2)

// ==========================================
// power-on phase length
`define POWER_ON_MS 2000
`define POWER_ON_CYCLES ((`CLOCK_HZ / 1000) * `POWER_ON_MS)

// ==========================================
// display source codes, in priority order
`define SRC_POWER_ON 3'h0
`define SRC_HARD 3'h1
`define SRC_MISMATCH 3'h2
`define SRC_SOFT 3'h3
`define SRC_NORMAL 3'h4

`endif

// >>> led_props.sv
// led_props.sv: timing checks on the status display block
// assumes binding onto status_led_fault_display with shortened counts
`timescale 1ns/1ps
`default_nettype none
module led_props #(
  parameter integer PORTS = 4,
  parameter integer ID_WIDTH = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // condition inputs
  input wire logic hw_fail,
  input wire logic base_param_err,
  input wire logic flash_param_err,
  input wire logic [PORTS-1:0] port_err,
  input wire logic [ID_WIDTH-1:0] module_model_id,
  input wire logic [ID_WIDTH-1:0] base_model_id,
  // driven outputs
  input wire logic use_flash_params,
  input wire logic [PORTS-1:0] port_enable,
  input wire logic supply_led,
  input wire logic run_led,
  input wire logic config_state_led,
  input wire logic send_activity_led,
  input wire logic fault_led,
  input wire logic power_on_phase,
  input wire logic mismatch
);
  // ==========================================
  // properties
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_supply; $past(rst_n) |-> supply_led; endproperty
  a_supply: assert property (p_supply) else $error("supply led dark");
  property p_pwron;
    power_on_phase && $past(rst_n) |->
      run_led && config_state_led && send_activity_led && fault_led;
  endproperty
  a_pwron: assert property (p_pwron) else $error("power-on pattern wrong");
  property p_fast;
    $rose(config_state_led) && mismatch && $past(mismatch)
      ##1 (mismatch && config_state_led == fault_led) [*2] |->
      !config_state_led && $past(config_state_led);
  endproperty
  a_fast: assert property (p_fast) else $error("fast blink width wrong");
  property p_slow;
    $fell(fault_led) && !mismatch && !$past(mismatch) |-> !fault_led [*7];
  endproperty
  a_slow: assert property (p_slow) else $error("slow blink width wrong");
  property p_hard;
    (hw_fail && !power_on_phase) [*5] |-> fault_led;
  endproperty
  a_hard: assert property (p_hard) else $error("hard failure not lit");
  property p_mism; (module_model_id != base_model_id) [*4] |-> mismatch; endproperty
  a_mism: assert property (p_mism) else $error("mismatch not flagged");
  property p_flash; (base_param_err && !flash_param_err) [*4] |-> use_flash_params; endproperty
  a_flash: assert property (p_flash) else $error("other store not used");
  property p_pdis;
    ($stable(port_err) && port_err != '0) [*4] |-> (port_enable & port_err) == '0;
  endproperty
  a_pdis: assert property (p_pdis) else $error("failed port left on");
  property p_alloff; (&port_err && !power_on_phase && !mismatch) [*5] |-> !run_led; endproperty
  a_alloff: assert property (p_alloff) else $error("run lit with all ports bad");
  property p_norm;
    (!hw_fail && !base_param_err && port_err == '0 && &port_enable && !mismatch
      && !power_on_phase) [*5] |-> run_led;
  endproperty
  a_norm: assert property (p_norm) else $error("run dark in normal state");
endmodule
bind status_led_fault_display led_props #(.PORTS(PORTS), .ID_WIDTH(ID_WIDTH)) led_props_i (
  .clock(clock), .rst_n(rst_n), .hw_fail(hw_fail), .base_param_err(base_param_err),
  .flash_param_err(flash_param_err),
  .port_err(port_err), .module_model_id(module_model_id), .base_model_id(base_model_id),
  .use_flash_params(use_flash_params), .port_enable(port_enable), .supply_led(supply_led),
  .run_led(run_led), .config_state_led(config_state_led),
  .send_activity_led(send_activity_led), .fault_led(fault_led),
  .power_on_phase(power_on_phase), .mismatch(mismatch));
`default_nettype wire

// >>> status_led_fault_display.v
// status_led_fault_display.v: front-panel LED selector with fault handling
// assumes fault and condition flags arrive from other clock domains or pins
//
// Overview of operation
// RL1: after power-on, the supply, run, config, send-activity and fault LEDs are lit steadily.
// RL2: once the power-on phase ends every LED follows the normal operation display.
// RL3: a module mismatch fast-blinks the run, config and fault LEDs while the supply stays lit.
// RL4: a mismatch is a model-id disagreement between module and base and is not a fault.
// RL5: a hard failure outranks the mismatch pattern.
// RL6: any hardware failure is a hard failure and lights the fault LED steadily.
// RL7: base or flash parameter errors and port errors are soft failures that slow-blink fault.
// RL8: on one parameter store failing, the copy from the other store is used and operation goes on.
// RL9: failed Ethernet ports are disabled and the run LED slow-blinks or goes off.
// RL10: fast blink has a 0.2 s period and slow blink a 1.4 s period.
// RL11: run slow-blinks when some ports fail, is off when all fail, and is lit otherwise.
// RL12: a single selector picks hard, then mismatch, then soft, then normal, every cycle.
`include "led_map.vh"
`timescale 1ns/1ps
`default_nettype none

module status_led_fault_display #(
  parameter integer PORTS = 4,
  parameter integer POWER_ON_CYCLES = `POWER_ON_CYCLES,
  parameter integer FAST_HALF = `FAST_HALF_CYCLES,
  parameter integer SLOW_HALF = `SLOW_HALF_CYCLES,
  parameter integer ID_WIDTH = 8
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // fault and condition inputs
  input wire hw_fail,
  input wire base_param_err,
  input wire flash_param_err,
  input wire [PORTS-1:0] port_err,
  input wire [ID_WIDTH-1:0] module_model_id,
  input wire [ID_WIDTH-1:0] base_model_id,
  // state inputs for the normal display
  input wire config_mode,
  input wire sending,
  input wire [1:0] chain_ring_state,
  input wire [1:0] between_ring_state,
  input wire [PORTS-1:0] port_link,
  input wire [PORTS-1:0] port_activity,
  // parameter source and port control
  output reg use_flash_params,
  output reg params_lost,
  output reg [PORTS-1:0] port_enable,
  // LED drive
  output reg supply_led,
  output reg run_led,
  output reg config_state_led,
  output reg send_activity_led,
  output reg chain_ring_state_led,
  output reg fault_led,
  output reg between_ring_state_led,
  output reg [PORTS-1:0] port_link_leds,
  // display status
  output reg power_on_phase,
  output reg mismatch
);

  // ring state codes: 0 ring normal, 1 non-ring, 2 broken somewhere, 3 broken next to us
  localparam [1:0] RING_OK = 2'h0;
  localparam [1:0] RING_NONE = 2'h1;
  localparam [1:0] RING_FAR = 2'h2;
  localparam [1:0] RING_NEAR = 2'h3;

  // ==========================================
  // input synchronisers
  localparam integer SW = 9 + 3 * PORTS + 2 * ID_WIDTH;
  wire [SW-1:0] raw = {hw_fail, base_param_err, flash_param_err, port_err, port_link,
    port_activity, module_model_id, base_model_id, config_mode, sending,
    chain_ring_state, between_ring_state};
  reg [SW-1:0] sync_a;
  reg [SW-1:0] sync_b;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= {SW{1'b0}};
      sync_b <= {SW{1'b0}};
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
    end
  end

  wire s_hw;
  wire s_base_err;
  wire s_flash_err;
  wire [PORTS-1:0] s_port_err;
  wire [PORTS-1:0] s_link;
  wire [PORTS-1:0] s_act;
  wire [ID_WIDTH-1:0] s_mod_id;
  wire [ID_WIDTH-1:0] s_base_id;
  wire s_cfg;
  wire s_send;
  wire [1:0] s_chain;
  wire [1:0] s_between;
  assign {s_hw, s_base_err, s_flash_err, s_port_err, s_link, s_act, s_mod_id, s_base_id,
    s_cfg, s_send, s_chain, s_between} = sync_b;

  // ==========================================
  // blink sources
  wire fast_wave;
  wire slow_wave;

  blink_gen #(.HALF_CYCLES(FAST_HALF)) u_fast ( // RL10
    .clock(clock),
    .rst_n(rst_n),
    .wave(fast_wave)
  );

  blink_gen #(.HALF_CYCLES(SLOW_HALF)) u_slow ( // RL10
    .clock(clock),
    .rst_n(rst_n),
    .wave(slow_wave)
  );

  // ring led pattern from a ring state code
  function ring_pattern;
    input [1:0] state;
    input fast;
    input slow;
    begin
      case (state)
        RING_NONE: ring_pattern = 1'b1;
        RING_FAR: ring_pattern = fast;
        RING_NEAR: ring_pattern = slow;
        default: ring_pattern = 1'b0;
      endcase
    end
  endfunction

  // ==========================================
  // power-on phase timer
  reg [31:0] po_count;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      po_count <= 32'h0;
      power_on_phase <= 1'b1;
    end else if (power_on_phase) begin
      if (po_count >= POWER_ON_CYCLES - 1) begin
        power_on_phase <= 1'b0; // RL2
      end else begin
        po_count <= po_count + 32'h1;
      end
    end
  end

  // ==========================================
  // fault classification
  wire any_port_err = |s_port_err;
  wire all_port_err = &s_port_err;
  wire soft_fail = s_base_err | s_flash_err | any_port_err; // RL7
  wire id_mismatch = (s_mod_id != s_base_id); // RL4

  // a failed port stays disabled until reset; a flickering port would otherwise flap the ring
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_enable <= {PORTS{1'b1}};
      use_flash_params <= 1'b0;
      params_lost <= 1'b0;
      mismatch <= 1'b0;
    end else begin
      port_enable <= port_enable & ~s_port_err; // RL9
      // base store is preferred; fall back to flash copy when base is bad and flash is good
      use_flash_params <= s_base_err & ~s_flash_err; // RL8
      params_lost <= s_base_err & s_flash_err;
      mismatch <= id_mismatch;
    end
  end

  // ==========================================
  // prioritised display selector
  reg [2:0] source;

  always @* begin
    if (power_on_phase) begin
      source = `SRC_POWER_ON;
    end else if (s_hw) begin
      source = `SRC_HARD; // RL5 RL12
    end else if (id_mismatch) begin
      source = `SRC_MISMATCH; // RL12
    end else if (soft_fail) begin
      source = `SRC_SOFT; // RL12
    end else begin
      source = `SRC_NORMAL; // RL12
    end
  end

  // normal-display run LED from port health
  reg normal_run;

  always @* begin
    if (all_port_err) begin
      normal_run = 1'b0; // RL11
    end else if (any_port_err) begin
      normal_run = slow_wave; // RL11
    end else begin
      normal_run = 1'b1;
    end
  end

  reg next_run;
  reg next_cfg;
  reg next_send;
  reg next_fault;

  always @* begin
    next_run = normal_run; // RL2
    next_cfg = s_cfg;
    next_send = s_send;
    next_fault = 1'b0;
    case (source)
      `SRC_POWER_ON: begin
        next_run = 1'b1; // RL1
        next_cfg = 1'b1; // RL1
        next_send = 1'b1; // RL1
        next_fault = 1'b1; // RL1
      end
      `SRC_HARD: begin
        next_fault = 1'b1; // RL6
      end
      `SRC_MISMATCH: begin
        next_run = fast_wave; // RL3
        next_cfg = fast_wave; // RL3
        next_fault = fast_wave; // RL3
      end
      `SRC_SOFT: begin
        next_fault = slow_wave; // RL7
        next_run = normal_run; // RL9
      end
      default: begin
        next_fault = 1'b0;
      end
    endcase
  end

  // ==========================================
  // LED output registers
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      supply_led <= 1'b0;
      run_led <= 1'b0;
      config_state_led <= 1'b0;
      send_activity_led <= 1'b0;
      chain_ring_state_led <= 1'b0;
      fault_led <= 1'b0;
      between_ring_state_led <= 1'b0;
      port_link_leds <= {PORTS{1'b0}};
    end else begin
      supply_led <= 1'b1; // RL1 RL2 RL3
      run_led <= next_run;
      config_state_led <= next_cfg;
      send_activity_led <= next_send;
      fault_led <= next_fault;
      chain_ring_state_led <= ring_pattern(s_chain, fast_wave, slow_wave);
      between_ring_state_led <= ring_pattern(s_between, fast_wave, slow_wave);
      // activity flashes the link LED with the fast wave
      port_link_leds <= s_link & port_enable & ~(s_act & {PORTS{fast_wave}});
    end
  end

endmodule

`default_nettype wire

// >>> tb_top.sv
// tb_top.sv: self-checking bench for the status display block
// assumes shortened power-on and blink counts set at the instance
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 0, rst_n = 0, hw_fail = 0, base_param_err = 0, flash_param_err = 0;
  logic config_mode = 0, sending = 0, sel = 0;
  logic [3:0] port_err = '0, port_link = '0, port_activity = '0;
  logic [7:0] module_model_id = '0, base_model_id = '0;
  logic [1:0] chain_ring_state = '0, between_ring_state = '0;
  wire use_flash_params, params_lost, supply_led, run_led, config_state_led;
  wire send_activity_led, chain_ring_state_led, fault_led, between_ring_state_led;
  wire power_on_phase, mismatch;
  wire [3:0] port_enable, port_link_leds;
  wire sig = sel ? run_led : fault_led;
  int n_mismatch = 0, checked = 0, p, ca = 0, cb = 0, cc = 0;
  logic [31:0] r;
  always #5 clock = ~clock;
  status_led_fault_display #(.POWER_ON_CYCLES(20), .FAST_HALF(2), .SLOW_HALF(7))
    status_led_fault_display_i (.clock(clock), .rst_n(rst_n), .hw_fail(hw_fail),
    .base_param_err(base_param_err), .flash_param_err(flash_param_err),
    .port_err(port_err), .module_model_id(module_model_id), .base_model_id(base_model_id),
    .config_mode(config_mode), .sending(sending), .chain_ring_state(chain_ring_state),
    .between_ring_state(between_ring_state), .port_link(port_link),
    .port_activity(port_activity), .use_flash_params(use_flash_params),
    .params_lost(params_lost), .port_enable(port_enable), .supply_led(supply_led),
    .run_led(run_led), .config_state_led(config_state_led),
    .send_activity_led(send_activity_led), .chain_ring_state_led(chain_ring_state_led),
    .fault_led(fault_led), .between_ring_state_led(between_ring_state_led),
    .port_link_leds(port_link_leds), .power_on_phase(power_on_phase), .mismatch(mismatch));
  // ==========================================
  // compare tasks
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_per(input string nm, input int e, input int g);
    checked++;
    if (g != e) begin
      n_mismatch++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // cycles between two rises of the selected led, bounded
  task per(output int n);
    int i, k;
    logic q;
    k = 0;
    n = 0;
    q = sig;
    for (i = 0; i < 100 && k < 2; i++) begin
      @(negedge clock);
      if (k == 1) n++;
      if (sig === 1'b1 && q === 1'b0) k++;
      q = sig;
    end
  endtask
  task settle;
    repeat (6) @(negedge clock);
  endtask
  task give_verdict;
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // stimulus
  initial begin
    #20000;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    r = $urandom(32'h3358);
    r = $urandom;
    repeat (6) @(negedge clock);
    rst_n = 1;
    @(negedge clock);
    chk("pwron", 8'h1f, {supply_led, run_led, config_state_led, send_activity_led, fault_led});
    {config_mode, sending, port_link} = r[5:0];
    chain_ring_state = {1'b0, r[6]};
    between_ring_state = {1'b0, r[7]};
    module_model_id = r[15:8];
    base_model_id = r[15:8];
    repeat (30) @(negedge clock);
    chk("normal", {3'h0, 2'h3, r[5], r[4], 1'b0},
      {supply_led, run_led, config_state_led, send_activity_led, fault_led});
    chk("ring", {r[6], r[7], r[3:0]},
      {chain_ring_state_led, between_ring_state_led, port_link_leds});
    // broken-ring codes and activity: count lit cycles over whole blink periods
    chain_ring_state = 2'h2;
    between_ring_state = 2'h3;
    port_activity = 4'hf;
    settle;
    repeat (28) begin
      @(negedge clock);
      ca += chain_ring_state_led;
      cb += between_ring_state_led;
      cc += $countones(port_link_leds);
    end
    chk_per("ringfast", 14, ca);
    chk_per("ringslow", 14, cb);
    chk_per("activity", 14 * $countones(r[3:0]), cc);
    base_model_id = r[15:8] ^ (8'h01 << r[18:16]);
    settle;
    chk("mism", 8'h01, mismatch);
    for (int s = 0; s < 2; s++) begin
      sel = s;
      per(p);
      chk_per("fast", 4, p);
    end
    config_mode = 0;
    hw_fail = 1;
    repeat (3) begin
      settle;
      chk("hard", 8'h01, fault_led);
    end
    base_model_id = r[15:8];
    settle;
    hw_fail = 0;
    // let the fault led sit dark for longer than a slow half period first
    repeat (2) settle;
    base_param_err = 1;
    settle;
    chk("store", 8'h03, {use_flash_params, run_led});
    sel = 0;
    per(p);
    chk_per("slow", 14, p);
    flash_param_err = 1;
    settle;
    chk("lost", 8'h02, {params_lost, use_flash_params});
    {base_param_err, flash_param_err} = 2'b00;
    port_err = 4'h1 << r[20:19];
    settle;
    chk("pen", ~(8'h01 << r[20:19]) & 8'h0f, port_enable);
    sel = 1;
    per(p);
    chk_per("runslow", 14, p);
    port_err = 4'hf;
    repeat (2) begin
      settle;
      chk("alloff", 8'h00, {port_enable, run_led});
    end
    give_verdict;
  end
endmodule
`default_nettype wire
